/* fpu_exc_map.vh */
`ifndef FPU_EXC_MAP_VH
`define FPU_EXC_MAP_VH

// register byte offsets
`define REG_STATUS       8'h00
`define REG_MASK         8'h04
`define REG_FLAGS        8'h08
`define REG_CMD          8'h0c
`define REG_CONV_PC      8'h10
`define REG_CONV_IAR     8'h14
`define REG_SRC_SE       8'h18
`define REG_SRC_MHI      8'h1c
`define REG_SRC_MLO      8'h20
`define REG_DST_SE       8'h24
`define REG_DST_MHI      8'h28
`define REG_DST_MLO      8'h2c
`define REG_WB_SE        8'h30
`define REG_WB_MTOP      8'h34
`define REG_WB_MHI       8'h38
`define REG_WB_MLO       8'h3c
`define REG_CTRL         8'h40

// status / mask bits
`define ST_CONV_BIT      0
`define ST_WB_BIT        1
`define ST_WIDTH         2

// flags register fields
`define FL_CONV_BIT      0
`define FL_WB_BIT        1
`define FL_POST_BIT      2
`define FL_PACKED_BIT    3
`define FL_SOURCE_TYPE_TAG_LSB      4
`define FL_DESTINATION_TYPE_TAG_LSB      8
`define FL_OPCLASS_LSB   12

// control register fields
`define CTRL_RELEASE_BIT 0
`define CTRL_ENABLE_BIT  1
`define CTRL_RESET       2'b10

// sticky bit position in the mantissa-top word
`define WB_STICKY_BIT    8

// command word opclass field
`define OPCLASS_MSB      15
`define OPCLASS_LSB      13
`define OPCLASS_REG_REG  3'h0
`define OPCLASS_MEM_REG  3'h2
`define OPCLASS_MOVE_OUT 3'h3

// conversion-stage fault kinds
`define KIND_OTHER       2'h0
`define KIND_UNIMPL      2'h1
`define KIND_UNSUPP      2'h2
`define KIND_SIGNALING_NAN_FAULT        2'h3

// operand type tags
`define TAG_NORM         3'h0
`define TAG_ZERO         3'h1
`define TAG_INF          3'h2
`define TAG_NAN          3'h3
`define TAG_EXT_DENORM   3'h4
`define TAG_SD_DENORM    3'h5

`endif

/* operand_pack.v */
`timescale 1ns/100ps
`default_nettype none
`include "fpu_exc_map.vh"

module operand_pack (
  input  wire        packed_src,
  input  wire        src_sign,
  input  wire [14:0] src_exp,
  input  wire [63:0] src_mant,
  input  wire [2:0]  src_tag,
  input  wire        dst_sign,
  input  wire [14:0] dst_exp,
  input  wire [63:0] dst_mant,
  input  wire [95:0] packed_operand,
  output reg         out_src_sign,
  output reg  [14:0] out_src_exp,
  output reg  [63:0] out_src_mant,
  output reg  [2:0]  out_src_tag,
  output reg         out_dst_sign,
  output reg  [14:0] out_dst_exp,
  output reg  [63:0] out_dst_mant
);

  always @* begin
    if (packed_src) begin
      // undefined fields are forced to zero for a repeatable frame
      out_src_sign = 1'b0;
      out_src_exp  = 15'h0000;
      out_src_mant = packed_operand[63:0];
      out_src_tag  = `TAG_NORM;
      out_dst_sign = 1'b0;
      out_dst_exp  = 15'h0000;
      out_dst_mant = {32'h00000000, packed_operand[95:64]};
    end else begin
      out_src_sign = src_sign;
      out_src_exp  = src_exp;
      out_src_mant = src_mant;
      out_src_tag  = src_tag;
      out_dst_sign = dst_sign;
      out_dst_exp  = dst_exp;
      out_dst_mant = dst_mant;
    end
  end

endmodule
`default_nettype wire

/* fpu_exception_state_frame.v */
`timescale 1ns/100ps
`default_nettype none
`include "fpu_exc_map.vh"

// Overview of operation
// - conversion-stage fault flag set whenever conversion stage reports any fault.
// - writeback flag only for overflow/underflow/inexact on arithmetic opclass 000/010.
// - unimplemented frame: packed flag set means packed decimal source type.
// - source temp holds extended source; packed puts bits 63-0 in mantissa.
// - destination temp holds extended operand; packed puts bits 95-64 low.
// - second opcode word stored unchanged; opclass is its bits 15-13.
// - type tags are 3-bit codes, normalized through single/double denormal.
// - source tag undefined when the source is packed decimal.
// - post-instruction flag set only for opclass 3 move-out faults.
// - writeback faults capture the intermediate sign, exponent, mantissa, sticky.
// - mantissa bit 66 overflow, bits 1,0 guard and round, sticky separate.
// - conversion-stage pc and instruction address are recorded.
// - unimplemented opclass 000/010: operands, tags, conv flag 1, post 0.
// - unsupported type opclass 000/010: operands, tags, conv flag 1, post 0.
// - unsupported type opclass 011: fp register source, tag, flags 1 and 1.
// - signaling nan opclass 000/010: operands, tags, conv flag 1, post 0.
module fpu_exception_state_frame (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         irq,
  input  wire        conv_fault,
  input  wire [1:0]  conv_fault_kind,
  input  wire [15:0] command_word,
  input  wire [31:0] conv_pc,
  input  wire [31:0] conv_instr_addr,
  input  wire        packed_src,
  input  wire [95:0] packed_operand,
  input  wire        src_sign,
  input  wire [14:0] src_exp,
  input  wire [63:0] src_mant,
  input  wire [2:0]  src_tag,
  input  wire        dst_sign,
  input  wire [14:0] dst_exp,
  input  wire [63:0] dst_mant,
  input  wire [2:0]  dst_tag,
  input  wire        fpreg_sign,
  input  wire [14:0] fpreg_exp,
  input  wire [63:0] fpreg_mant,
  input  wire        wb_fault,
  input  wire        overflow_fault,
  input  wire        underflow_fault,
  input  wire        inexact_round_fault,
  input  wire        wb_arith_op,
  input  wire [2:0]  wb_opclass,
  input  wire        wb_sign,
  input  wire [15:0] wb_exp,
  input  wire [66:0] wb_mant,
  input  wire        wb_sticky
);

  function is_arith_class;
    input [2:0] oc;
    begin
      is_arith_class = (oc == `OPCLASS_REG_REG) || (oc == `OPCLASS_MEM_REG);
    end
  endfunction

  // software-visible state
  reg [`ST_WIDTH-1:0] status;
  reg [`ST_WIDTH-1:0] mask;
  reg                 capture_enable;
  reg                 conversion_stage_fault;
  reg                 writeback_stage_fault;
  reg                 post_instruction;
  reg                 packed_flag;
  reg [15:0]          captured_command_word;
  reg [31:0]          conversion_stage_pc;
  reg [31:0]          conversion_stage_instr_addr;
  reg                 source_temp_sign;
  reg [14:0]          source_temp_exponent;
  reg [63:0]          source_temp_mantissa;
  reg [2:0]           source_type_tag;
  reg                 destination_temp_sign;
  reg [14:0]          destination_temp_exponent;
  reg [63:0]          destination_temp_mantissa;
  reg [2:0]           destination_type_tag;
  reg                 intermediate_sign;
  reg [15:0]          intermediate_exponent;
  reg [66:0]          intermediate_mantissa;
  reg                 sticky_flag;

  wire        pk_src_sign;
  wire [14:0] pk_src_exp;
  wire [63:0] pk_src_mant;
  wire [2:0]  pk_src_tag;
  wire        pk_dst_sign;
  wire [14:0] pk_dst_exp;
  wire [63:0] pk_dst_mant;

  operand_pack i_operand_pack (
    .packed_src     (packed_src),
    .src_sign       (src_sign),
    .src_exp        (src_exp),
    .src_mant       (src_mant),
    .src_tag        (src_tag),
    .dst_sign       (dst_sign),
    .dst_exp        (dst_exp),
    .dst_mant       (dst_mant),
    .packed_operand (packed_operand),
    .out_src_sign   (pk_src_sign),
    .out_src_exp    (pk_src_exp),
    .out_src_mant   (pk_src_mant),
    .out_src_tag    (pk_src_tag),
    .out_dst_sign   (pk_dst_sign),
    .out_dst_exp    (pk_dst_exp),
    .out_dst_mant   (pk_dst_mant)
  );

  wire [2:0] cmd_opclass = command_word[`OPCLASS_MSB:`OPCLASS_LSB];
  wire       move_out    = (cmd_opclass == `OPCLASS_MOVE_OUT);
  wire       arith_class = is_arith_class(cmd_opclass);

  // a held frame is never overwritten, so the saved view matches the fault
  wire conv_take = capture_enable & conv_fault & ~conversion_stage_fault;
  wire wb_cause  = overflow_fault | underflow_fault | inexact_round_fault;
  wire wb_take   = capture_enable & wb_fault & wb_cause & wb_arith_op &
                   is_arith_class(wb_opclass) & ~writeback_stage_fault;

  // apb decode
  wire setup_ph  = psel & ~penable;
  wire done_rd   = psel & penable & pready & ~pwrite;
  wire done_wr   = psel & penable & pready & pwrite;
  wire release_w = done_wr & (paddr == `REG_CTRL) &
                   pwdata[`CTRL_RELEASE_BIT];

  reg        next_mapped;
  reg [31:0] next_rdata;

  always @* begin
    next_mapped = 1'b1;
    next_rdata  = 32'h00000000;
    case (paddr)
      `REG_STATUS: next_rdata[`ST_WIDTH-1:0] = status;
      `REG_MASK:   next_rdata[`ST_WIDTH-1:0] = mask;
      `REG_FLAGS: begin
        next_rdata[`FL_CONV_BIT]   = conversion_stage_fault;
        next_rdata[`FL_WB_BIT]     = writeback_stage_fault;
        next_rdata[`FL_POST_BIT]   = post_instruction;
        next_rdata[`FL_PACKED_BIT] = packed_flag;
        next_rdata[`FL_SOURCE_TYPE_TAG_LSB+2:`FL_SOURCE_TYPE_TAG_LSB] = source_type_tag;
        next_rdata[`FL_DESTINATION_TYPE_TAG_LSB+2:`FL_DESTINATION_TYPE_TAG_LSB] = destination_type_tag;
        next_rdata[`FL_OPCLASS_LSB+2:`FL_OPCLASS_LSB] =
          captured_command_word[`OPCLASS_MSB:`OPCLASS_LSB];
      end
      `REG_CMD:      next_rdata[15:0] = captured_command_word;
      `REG_CONV_PC:  next_rdata = conversion_stage_pc;
      `REG_CONV_IAR: next_rdata = conversion_stage_instr_addr;
      `REG_SRC_SE:
        next_rdata = {source_temp_sign, 16'h0000, source_temp_exponent};
      `REG_SRC_MHI:  next_rdata = source_temp_mantissa[63:32];
      `REG_SRC_MLO:  next_rdata = source_temp_mantissa[31:0];
      `REG_DST_SE: next_rdata = {destination_temp_sign, 16'h0000,
                                 destination_temp_exponent};
      `REG_DST_MHI:  next_rdata = destination_temp_mantissa[63:32];
      `REG_DST_MLO:  next_rdata = destination_temp_mantissa[31:0];
      `REG_WB_SE:
        next_rdata = {intermediate_sign, 15'h0000, intermediate_exponent};
      `REG_WB_MTOP: begin
        next_rdata[2:0] = intermediate_mantissa[66:64];
        next_rdata[`WB_STICKY_BIT] = sticky_flag;
      end
      `REG_WB_MHI:   next_rdata = intermediate_mantissa[63:32];
      `REG_WB_MLO:   next_rdata = intermediate_mantissa[31:0];
      `REG_CTRL:     next_rdata[`CTRL_ENABLE_BIT] = capture_enable;
      default:       next_mapped = 1'b0;
    endcase
  end

  // mask write acts on irq in the same edge as the register
  reg [`ST_WIDTH-1:0] next_mask;

  always @* begin
    next_mask = mask;
    if (done_wr && paddr == `REG_MASK)
      next_mask = pwdata[`ST_WIDTH-1:0];
  end

  localparam [1:0] CTRL_INIT = `CTRL_RESET;

  // sticky events: a new capture in the read-clear cycle stays set
  reg [`ST_WIDTH-1:0] next_status;

  always @* begin
    next_status = status;
    if (done_rd && paddr == `REG_STATUS)
      next_status = {`ST_WIDTH{1'b0}};
    if (conv_take)
      next_status[`ST_CONV_BIT] = 1'b1;
    if (wb_take)
      next_status[`ST_WB_BIT] = 1'b1;
  end

  // bus slave: answer prepared in setup, so access phase is one cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph & ~next_mapped;
      if (setup_ph && !pwrite)
        prdata <= next_rdata;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status         <= {`ST_WIDTH{1'b0}};
      mask           <= {`ST_WIDTH{1'b0}};
      capture_enable <= CTRL_INIT[`CTRL_ENABLE_BIT];
      irq            <= 1'b0;
    end else begin
      status <= next_status;
      irq    <= |(next_status & next_mask);
      mask   <= next_mask;
      if (done_wr && paddr == `REG_CTRL)
        capture_enable <= pwdata[`CTRL_ENABLE_BIT];
    end
  end

  // conversion-stage context
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_stage_fault      <= 1'b0;
      post_instruction            <= 1'b0;
      packed_flag                 <= 1'b0;
      captured_command_word       <= 16'h0000;
      conversion_stage_pc         <= 32'h00000000;
      conversion_stage_instr_addr <= 32'h00000000;
      source_temp_sign            <= 1'b0;
      source_temp_exponent        <= 15'h0000;
      source_temp_mantissa        <= 64'h0000000000000000;
      source_type_tag             <= `TAG_NORM;
      destination_temp_sign       <= 1'b0;
      destination_temp_exponent   <= 15'h0000;
      destination_temp_mantissa   <= 64'h0000000000000000;
      destination_type_tag        <= `TAG_NORM;
    end else if (conv_take) begin
      conversion_stage_fault      <= 1'b1;
      post_instruction            <= move_out;
      captured_command_word       <= command_word;
      conversion_stage_pc         <= conv_pc;
      conversion_stage_instr_addr <= conv_instr_addr;
      if (move_out) begin
        // unrounded register source, no destination operand
        packed_flag               <= 1'b0;
        source_temp_sign          <= fpreg_sign;
        source_temp_exponent      <= fpreg_exp;
        source_temp_mantissa      <= fpreg_mant;
        source_type_tag           <= src_tag;
        destination_type_tag      <= `TAG_NORM;
      end else begin
        // opclass 000/010 and any other kind share this frame layout
        packed_flag               <= packed_src &
                                     (conv_fault_kind == `KIND_UNIMPL ||
                                      conv_fault_kind == `KIND_UNSUPP);
        source_temp_sign          <= pk_src_sign;
        source_temp_exponent      <= pk_src_exp;
        source_temp_mantissa      <= pk_src_mant;
        source_type_tag           <= pk_src_tag;
        destination_temp_sign     <= pk_dst_sign;
        destination_temp_exponent <= pk_dst_exp;
        destination_temp_mantissa <= pk_dst_mant;
        destination_type_tag      <= arith_class ? dst_tag : `TAG_NORM;
      end
    end else if (release_w) begin
      conversion_stage_fault      <= 1'b0;
      post_instruction            <= 1'b0;
      packed_flag                 <= 1'b0;
    end
  end

  // writeback-stage context
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      writeback_stage_fault <= 1'b0;
      intermediate_sign     <= 1'b0;
      intermediate_exponent <= 16'h0000;
      intermediate_mantissa <= 67'h0;
      sticky_flag           <= 1'b0;
    end else if (wb_take) begin
      writeback_stage_fault <= 1'b1;
      intermediate_sign     <= wb_sign;
      intermediate_exponent <= wb_exp;
      intermediate_mantissa <= wb_mant;
      sticky_flag           <= wb_sticky;
    end else if (release_w) begin
      writeback_stage_fault <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* fpu_exc_props.sv */
`timescale 1ns/100ps
`default_nettype none
module fpu_exc_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq,
  input wire logic        conv_fault,
  input wire logic        wb_fault,
  input wire logic        overflow_fault,
  input wire logic        underflow_fault,
  input wire logic        inexact_round_fault,
  input wire logic        wb_arith_op,
  input wire logic [2:0]  wb_opclass
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire bad = paddr > 8'h40 || paddr[1:0] != 2'b00;
  wire wr = psel && penable && pwrite;
  wire wb_ok = wb_fault && wb_arith_op
    && (overflow_fault || underflow_fault || inexact_round_fault)
    && (wb_opclass == 3'h0 || wb_opclass == 3'h2);
  sequence s_setup; psel && !penable; endsequence
  sequence s_done; psel && penable && pready; endsequence
  property p_ready; s_setup |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready held too long");
  property p_err; s_done ##0 bad |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("unmapped not refused");
  property p_ok; s_done ##0 !bad |-> !pslverr; endproperty
  a_ok: assert property (p_ok) else $error("mapped access refused");
  property p_zero; s_done ##0 (bad && !pwrite) |-> prdata == 32'h0;
  endproperty
  a_zero: assert property (p_zero) else $error("unmapped read not zero");
  property p_hold; !(psel && !penable && !pwrite) |=> $stable(prdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_irq_src;
    $rose(irq) |-> $past(conv_fault || wb_ok || wr);
  endproperty
  a_irq_src: assert property (p_irq_src) else $error("irq without cause");
  property p_wb_only;
    wb_fault && !wb_ok && !conv_fault && !wr |=> !$rose(irq);
  endproperty
  a_wb_only: assert property (p_wb_only) else $error("wb fault unqualified");
  property p_clear;
    s_done ##0 (!pwrite && paddr == 8'h00 && !conv_fault && !wb_fault)
      |=> !irq;
  endproperty
  a_clear: assert property (p_clear) else $error("irq kept after read");
endmodule
bind fpu_exception_state_frame fpu_exc_props i_fpu_exc_props (.*);
`default_nettype wire

/* fpu_exception_state_frame_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "fpu_exc_map.vh"
module fpu_exception_state_frame_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, conv_pc = 0, conv_instr_addr = 0, rd, seed;
  wire [31:0] prdata;
  wire pready, pslverr, irq;
  logic conv_fault = 0, packed_src = 0, src_sign = 0, dst_sign = 0, er;
  logic fpreg_sign = 0, wb_fault = 0, overflow_fault = 0, wb_sign = 0;
  logic underflow_fault = 0, inexact_round_fault = 0, wb_arith_op = 0;
  logic wb_sticky = 0;
  logic [1:0] conv_fault_kind = 0;
  logic [15:0] command_word = 0, wb_exp = 0;
  logic [95:0] packed_operand = 0;
  logic [14:0] src_exp = 0, dst_exp = 0, fpreg_exp = 0;
  logic [63:0] src_mant = 0, dst_mant = 0, fpreg_mant = 0;
  logic [2:0] src_tag = 0, dst_tag = 0, wb_opclass = 0;
  logic [66:0] wb_mant = 0;
  int fails = 0, check_count = 0, cyc = 0;
  fpu_exception_state_frame i_fpu_exception_state_frame (.*);
  always #2 pclk = ~pclk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string n, input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      report_and_stop();
    end
  end
  // one idle cycle after each transfer keeps drivers single per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk); penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; er = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task automatic pulse();
    conv_fault <= 1;
    @(posedge pclk); conv_fault <= 0;
  endtask
  task automatic conv(input logic [1:0] k, input logic [2:0] oc, input logic pk);
    logic [31:0] r, a, b;
    logic [15:0] cw;
    logic p, d;
    r = xs(); a = xs(); b = xs();
    conv_fault_kind <= k; command_word <= {oc, r[12:0]}; packed_src <= pk;
    conv_pc <= xs(); conv_instr_addr <= xs();
    packed_operand <= {xs(), xs(), xs()};
    {src_sign, src_exp} <= a[15:0]; {dst_sign, dst_exp} <= a[31:16];
    {fpreg_sign, fpreg_exp} <= b[15:0];
    src_tag <= r[14:13] + r[15] + r[16]; dst_tag <= r[18:17] + r[19] + r[20];
    src_mant <= {xs(), xs()}; dst_mant <= {xs(), xs()};
    fpreg_mant <= {xs(), xs()};
    pulse();
    p = pk && (k == 1 || k == 2);
    d = oc == 0 || oc == 2;
    apb(0, `REG_FLAGS, 0);
    chk("flags", rd, {17'h0, oc, 1'b0, d ? dst_tag : 3'h0, 1'b0,
      p ? 3'h0 : src_tag, p, oc == 3, 2'b01});
    apb(0, `REG_CMD, 0); chk("cmd", rd, {16'h0, command_word});
    apb(0, `REG_CONV_PC, 0); chk("pc", rd, conv_pc);
    apb(0, `REG_CONV_IAR, 0); chk("iar", rd, conv_instr_addr);
    apb(0, `REG_SRC_SE, 0);
    chk("src_se", rd, p ? 32'h0 : oc == 3 ? {fpreg_sign, 16'h0, fpreg_exp}
      : {src_sign, 16'h0, src_exp});
    apb(0, `REG_SRC_MHI, 0);
    chk("src_mhi", rd, p ? packed_operand[63:32] : oc == 3 ?
      fpreg_mant[63:32] : src_mant[63:32]);
    apb(0, `REG_SRC_MLO, 0);
    chk("src_mlo", rd, p ? packed_operand[31:0] : oc == 3 ?
      fpreg_mant[31:0] : src_mant[31:0]);
    if (d) begin
      apb(0, `REG_DST_SE, 0);
      chk("dst_se", rd, p ? 32'h0 : {dst_sign, 16'h0, dst_exp});
      apb(0, `REG_DST_MHI, 0);
      chk("dst_mhi", rd, p ? 32'h0 : dst_mant[63:32]);
      apb(0, `REG_DST_MLO, 0);
      chk("dst_mlo", rd, p ? packed_operand[95:64] : dst_mant[31:0]);
    end
    chk("irq", irq, 1);
    apb(0, `REG_STATUS, 0); chk("status", rd, 1);
    chk("irq", irq, 0);
    cw = command_word;
    command_word <= ~cw;
    pulse();
    apb(0, `REG_CMD, 0); chk("cmd held", rd, {16'h0, cw});
    apb(0, `REG_STATUS, 0); chk("status", rd, 0);
    apb(1, `REG_CTRL, 3);
  endtask
  task automatic wb(input logic o, u, i, a, input logic [2:0] oc);
    logic [31:0] r;
    logic q;
    r = xs();
    overflow_fault <= o; underflow_fault <= u; inexact_round_fault <= i;
    wb_arith_op <= a; wb_opclass <= oc; wb_sign <= r[0]; wb_sticky <= r[1];
    wb_exp <= r[31:16]; wb_mant <= {r[4:2], xs(), xs()}; wb_fault <= 1;
    @(posedge pclk); wb_fault <= 0;
    q = (o | u | i) & a & (oc == 0 || oc == 2);
    apb(0, `REG_FLAGS, 0); chk("wb flag", rd & 32'h2, {30'h0, q, 1'b0});
    if (q) begin
      apb(0, `REG_WB_SE, 0); chk("wb_se", rd, {wb_sign, 15'h0, wb_exp});
      apb(0, `REG_WB_MTOP, 0);
      chk("wb_top", rd, {23'h0, wb_sticky, 5'h0, wb_mant[66:64]});
      apb(0, `REG_WB_MHI, 0); chk("wb_mhi", rd, wb_mant[63:32]);
      apb(0, `REG_WB_MLO, 0); chk("wb_mlo", rd, wb_mant[31:0]);
    end
    apb(0, `REG_STATUS, 0); chk("wb status", rd, {30'h0, q, 1'b0});
    apb(1, `REG_CTRL, 3);
  endtask
  initial begin
    logic [31:0] r;
    seed = 32'hb151;
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, `REG_FLAGS, 0); chk("rst flags", rd, 0);
    apb(0, `REG_MASK, 0); chk("rst mask", rd, 0);
    apb(0, `REG_CMD, 0); chk("rst cmd", rd, 0);
    apb(0, `REG_CTRL, 0); chk("rst ctrl", rd & 32'h2, 32'h2);
    chk("rst irq", irq, 0);
    $display("end reset");
    apb(0, 8'h44, 0); chk("err", er, 1); chk("err data", rd, 0);
    apb(1, 8'h42, 32'hffff); chk("err wr", er, 1);
    $display("end unmapped");
    apb(1, `REG_MASK, 3);
    for (int k = 0; k < 4; k++)
      for (int j = 0; j < 3; j++) conv(k, j == 0 ? 0 : j == 1 ? 2 : 3, 0);
    conv(1, 0, 1);
    conv(2, 2, 1);
    $display("end conv");
    for (int n = 0; n < 24; n++) begin
      r = xs();
      wb(r[0], r[1], r[2], r[3] | r[4], r[7:5]);
    end
    wb(1, 0, 0, 1, 0);
    wb(0, 1, 0, 1, 2);
    wb(0, 0, 1, 1, 3);
    $display("end wb");
    // handler order: writeback flag looked at before conversion flag
    conv_fault <= 1; wb_fault <= 1; overflow_fault <= 1;
    wb_arith_op <= 1; wb_opclass <= 0;
    @(posedge pclk); conv_fault <= 0; wb_fault <= 0;
    apb(0, `REG_FLAGS, 0);
    chk("wb first", rd[1], 1);
    chk("conv next", rd[0], 1);
    apb(0, `REG_STATUS, 0); chk("both status", rd, 3);
    apb(1, `REG_CTRL, 3);
    $display("end order");
    apb(1, `REG_MASK, 0);
    pulse();
    apb(0, `REG_FLAGS, 0); chk("masked irq", irq, 0);
    apb(1, `REG_MASK, 1); chk("unmasked irq", irq, 1);
    apb(0, `REG_STATUS, 0); chk("cleared irq", irq, 0);
    apb(1, `REG_CTRL, 3);
    $display("end mask");
    apb(1, `REG_CTRL, 0);
    pulse();
    apb(0, `REG_FLAGS, 0); chk("disabled", rd & 32'h1, 0);
    apb(1, `REG_CTRL, 2);
    $display("end disable");
    report_and_stop();
  end
endmodule
`default_nettype wire
